// ---- logic/sdlc_enh_pkg.sv ----
package sdlc_enh_pkg;
    localparam int count_w = 14;
    localparam int status_w = 5;
    // register indices, bit 3 is the upper-bank selector
    localparam logic [3:0] reg_main_status = 4'h0;
    localparam logic [3:0] reg_special_rx = 4'h1;
    localparam logic [3:0] reg_irq_vector = 4'h2;
    localparam logic [3:0] reg_pending_irq = 4'h3;
    localparam logic [3:0] reg_rx_param = 4'h3;
    localparam logic [3:0] reg_txrx_mode = 4'h4;
    localparam logic [3:0] reg_tx_param = 4'h5;
    localparam logic [3:0] reg_frame_low = 4'h6;
    localparam logic [3:0] reg_frame_high = 4'h7;
    localparam logic [3:0] reg_flag_pattern = 4'h7;
    localparam logic [3:0] reg_master_irq = 4'h9;
    localparam logic [3:0] reg_misc_ctrl = 4'ha;
    localparam logic [3:0] reg_ext_b = 4'hb;
    localparam logic [3:0] reg_ext_d = 4'hd;
    localparam logic [3:0] reg_ext_e = 4'he;
    localparam logic [3:0] reg_enh_enable = 4'hf;
    // enhancement enable fields
    localparam int enh_opt_bit = 0;
    localparam int enh_fifo_bit = 2;
    // option register fields
    localparam int opt_auto_flag = 0;
    localparam int opt_auto_eom = 1;
    localparam int opt_auto_rts = 2;
    localparam int opt_force_txd = 3;
    localparam int opt_fast_req = 4;
    localparam int opt_rx_crc = 5;
    localparam int opt_ext_read = 6;
    localparam int opt_must_zero = 7;
    // misc control idle bits needed by auto rts
    localparam int misc_idle_bit = 3;
    localparam int misc_abort_bit = 2;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [count_w-1:0] count_zero = 14'h0000;
    localparam logic [1:0] crc_tail_bits = 2'h2;
    localparam int buf_depth = 2;

    typedef struct packed {
        logic [count_w-1:0] count;
        logic [status_w-1:0] status;
    } frame_entry_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic chan;
        logic [3:0] idx;
        logic [7:0] wdata;
    } host_req_t;
endpackage

// ---- logic/frame_entry_buf.sv ----
`timescale 1ns/100ps
module frame_entry_buf
    import sdlc_enh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire frame_entry_t in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output frame_entry_t out_data
);
    typedef struct packed {
        frame_entry_t [buf_depth-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] used;
    } buf_state_t;

    buf_state_t st;
    buf_state_t next_st;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid && (st.used != 2'(buf_depth));
        pop = out_valid && out_ready;
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = ~st.wp;
        end
        if (pop) begin
            next_st.rp = ~st.rp;
        end
        next_st.used = st.used + 2'(push) - 2'(pop);
        if (flush) begin
            next_st.wp = 1'b0;
            next_st.rp = 1'b0;
            next_st.used = 2'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = st.used != 2'(buf_depth);
    assign out_valid = st.used != 2'h0;
    assign out_data = st.mem[st.rp];
endmodule // frame_entry_buf

// ---- logic/sdlc_enhancement_register_map.sv ----
`timescale 1ns/100ps
module sdlc_enhancement_register_map
    import sdlc_enh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic chan_reset,
    // host register access, same clock domain
    input wire host_req_t host,
    output logic [7:0] rdata,
    // core status images, per channel except the shared pending_irq
    input wire logic [7:0] main_status_a,
    input wire logic [7:0] main_status_b,
    input wire logic [7:0] special_rx_a,
    input wire logic [7:0] special_rx_b,
    input wire logic [7:0] vector_readback_a,
    input wire logic [7:0] vector_readback_b,
    input wire logic [7:0] pending_irq,
    input wire logic [7:0] upper_status_a,
    input wire logic [7:0] upper_status_b,
    input wire logic sdlc_mode_a,
    input wire logic sdlc_mode_b,
    // receiver events per channel, bit 1 is channel A
    input wire logic [1:0] rx_fifo_write,
    input wire logic [1:0] rx_flag_seen,
    input wire logic [1:0] rx_end_of_frame,
    input wire logic [status_w-1:0] rx_status_a,
    input wire logic [status_w-1:0] rx_status_b,
    // transmitter events per channel
    input wire logic [1:0] rts_host,
    input wire logic [1:0] closing_flag_done,
    // frame status drain, bit 1 is channel A
    output logic [1:0] frame_valid,
    input wire logic [1:0] frame_ready,
    output frame_entry_t frame_a,
    output frame_entry_t frame_b,
    // channel control outputs
    output logic [1:0] rts_out,
    output logic [1:0] crc_tail_shift,
    output logic [1:0] fifo_enabled,
    output logic [7:0] option_a,
    output logic [7:0] option_b
);
    typedef struct packed {
        logic [7:0] enh_enable;
        logic [7:0] sdlc_option;
        logic [7:0] rx_param;
        logic [7:0] txrx_mode;
        logic [7:0] tx_param;
        logic [7:0] misc_ctrl;
        logic [7:0] flag_pattern;
        logic [count_w-1:0] count;
        logic [status_w-1:0] last_status;
        logic [count_w-1:0] last_count;
        logic rts;
        logic crc_shift;
        logic [1:0] crc_left;
        logic fifo_on;
        logic overflow;
    } chan_t;

    typedef struct packed {
        chan_t [1:0] ch;
        logic [7:0] irq_vector;
        logic [7:0] master_irq;
        logic [7:0] rdata;
        logic [1:0] push;
    } state_t;

    state_t st;
    state_t next_st;
    logic [1:0] buf_in_ready;
    frame_entry_t [1:0] buf_in;
    frame_entry_t [1:0] buf_out;
    logic [1:0] sdlc_mode;
    logic [1:0] buf_valid;

    assign sdlc_mode = {sdlc_mode_a, sdlc_mode_b};

    function automatic logic count_enabled(input chan_t c, input logic sdlc);
        return sdlc && c.enh_enable[enh_fifo_bit];
    endfunction

    function automatic logic ext_read(input chan_t c);
        return c.enh_enable[enh_opt_bit] && c.sdlc_option[opt_ext_read];
    endfunction

    // read mux; the remap depends on both enables of the addressed channel
    function automatic logic [7:0] read_reg(input chan_t c, input logic [3:0] idx,
                                            input logic [7:0] s0, input logic [7:0] s1,
                                            input logic [7:0] s2, input logic [7:0] s3,
                                            input logic [7:0] up);
        logic fifo;
        logic ext;
        logic [7:0] v;
        fifo = c.enh_enable[enh_fifo_bit];
        ext = ext_read(c);
        v = up;
        unique case (idx)
            reg_main_status: v = s0;
            reg_special_rx: v = s1;
            reg_irq_vector: v = s2;
            reg_pending_irq: v = s3;
            reg_txrx_mode: v = ext ? c.txrx_mode : s0;
            reg_tx_param: v = ext ? c.tx_param : s1;
            reg_frame_low: begin
                if (fifo) begin
                    v = c.last_count[7:0];
                end else begin
                    v = s2;
                end
            end
            reg_frame_high: begin
                if (fifo) begin
                    v = {c.overflow, buf_nonempty(c), c.last_count[count_w-1:8]};
                end else begin
                    v = s3;
                end
            end
            reg_master_irq: begin
                if (ext) begin
                    v = c.rx_param;
                end else if (fifo) begin
                    v = up; // upper image of 13 arrives on up for this slot
                end
            end
            reg_ext_b: v = ext ? c.misc_ctrl : up;
            reg_ext_e: v = ext ? c.sdlc_option : up;
            default: v = up;
        endcase
        return v;
    endfunction

    function automatic logic buf_nonempty(input chan_t c);
        return c.fifo_on;
    endfunction

    always_comb begin
        chan_t c;
        logic [7:0] s0;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] up;
        c = '0;
        s0 = 8'h00;
        s1 = 8'h00;
        s2 = 8'h00;
        up = 8'h00;
        next_st = st;
        next_st.push = 2'b00;
        for (int i = 0; i < 2; i++) begin
            c = st.ch[i];
            // host write; the two shared registers ignore the channel select
            if (host.wr && host.chan == 1'(i)) begin
                unique case (host.idx)
                    reg_rx_param: c.rx_param = host.wdata;
                    reg_txrx_mode: c.txrx_mode = host.wdata;
                    reg_tx_param: c.tx_param = host.wdata;
                    reg_flag_pattern: begin
                        if (c.enh_enable[enh_opt_bit]) begin
                            c.sdlc_option = host.wdata;
                            c.sdlc_option[opt_must_zero] = 1'b0;
                        end else begin
                            c.flag_pattern = host.wdata;
                        end
                    end
                    reg_misc_ctrl: c.misc_ctrl = host.wdata;
                    reg_enh_enable: begin
                        c.enh_enable = host.wdata;
                        if (!host.wdata[enh_fifo_bit]) begin
                            c.overflow = 1'b0;
                        end
                    end
                    default: c = c;
                endcase
            end
            // byte counter
            if (!count_enabled(st.ch[i], sdlc_mode[i])) begin
                c.count = count_zero;
            end else if (rx_end_of_frame[i] || rx_flag_seen[i]) begin
                if (rx_end_of_frame[i]) begin
                    // capture before clearing
                    next_st.push[i] = 1'b1;
                    c.last_count = st.ch[i].count;
                    c.last_status = (i == 1) ? rx_status_a : rx_status_b;
                    if (!buf_in_ready[i]) begin
                        c.overflow = 1'b1;
                    end
                end
                c.count = count_zero;
            end else if (rx_fifo_write[i]) begin
                c.count = st.ch[i].count + 14'h0001;
            end
            c.fifo_on = buf_valid[i];
            // auto rts turnoff holds rts until the closing flag leaves
            if (rts_host[i]) begin
                c.rts = 1'b1;
            end else if (c.enh_enable[enh_opt_bit] && c.sdlc_option[opt_auto_rts] && sdlc_mode[i]
                         && c.misc_ctrl[misc_idle_bit] && !c.misc_ctrl[misc_abort_bit]) begin
                if (closing_flag_done[i]) begin
                    c.rts = 1'b0;
                end
            end else begin
                c.rts = 1'b0;
            end
            // full crc reception: two extra shift clocks at end of frame
            c.crc_shift = 1'b0;
            if (st.ch[i].crc_left != 2'h0) begin
                c.crc_shift = 1'b1;
                c.crc_left = st.ch[i].crc_left - 2'h1;
            end else if (rx_end_of_frame[i] && c.enh_enable[enh_opt_bit] && c.sdlc_option[opt_rx_crc]) begin
                c.crc_left = crc_tail_bits;
            end
            if (chan_reset) begin
                c = '0;
            end
            next_st.ch[i] = c;
        end
        if (host.wr && host.idx == reg_irq_vector) begin
            next_st.irq_vector = host.wdata;
        end
        if (host.wr && host.idx == reg_master_irq) begin
            next_st.master_irq = host.wdata;
        end
        if (host.chan) begin
            s0 = main_status_a;
            s1 = special_rx_a;
            s2 = vector_readback_a;
            up = upper_status_a;
        end else begin
            s0 = main_status_b;
            s1 = special_rx_b;
            s2 = vector_readback_b;
            up = upper_status_b;
        end
        if (host.rd) begin
            next_st.rdata = read_reg(st.ch[host.chan], host.idx, s0, s1, s2, pending_irq, up);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // one status buffer per channel; a stall by the drain side holds entries
    for (genvar g = 0; g < 2; g++) begin : g_buf
        assign buf_in[g] = '{count: st.ch[g].last_count, status: st.ch[g].last_status};
        frame_entry_buf u_buf (
            .clk(clk),
            .resetn(resetn),
            .flush(chan_reset || !st.ch[g].enh_enable[enh_fifo_bit]),
            .in_valid(st.push[g]),
            .in_ready(buf_in_ready[g]),
            .in_data(buf_in[g]),
            .out_valid(buf_valid[g]),
            .out_ready(frame_ready[g]),
            .out_data(buf_out[g])
        );
    end

    assign rdata = st.rdata;
    assign frame_valid = buf_valid;
    assign frame_a = buf_out[1];
    assign frame_b = buf_out[0];
    assign rts_out = {st.ch[1].rts, st.ch[0].rts};
    assign crc_tail_shift = {st.ch[1].crc_shift, st.ch[0].crc_shift};
    assign fifo_enabled = {st.ch[1].enh_enable[enh_fifo_bit], st.ch[0].enh_enable[enh_fifo_bit]};
    assign option_a = st.ch[1].sdlc_option;
    assign option_b = st.ch[0].sdlc_option;
endmodule // sdlc_enhancement_register_map

// ---- tb/sdlc_enh_assertions.sv ----
`timescale 1ns/100ps
module sdlc_enh_checker
    import sdlc_enh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic chan_reset,
    // host side
    input wire host_req_t host,
    input wire logic [7:0] rdata,
    // channel events and outputs
    input wire logic sdlc_mode_a,
    input wire logic [1:0] rx_end_of_frame,
    input wire logic [1:0] rts_host,
    input wire logic [1:0] closing_flag_done,
    input wire logic [1:0] frame_valid,
    input wire logic [1:0] frame_ready,
    input wire frame_entry_t frame_a,
    input wire logic [1:0] rts_out,
    input wire logic [1:0] crc_tail_shift,
    input wire logic [1:0] fifo_enabled,
    input wire logic [7:0] option_a
);
    // enable and misc control have no port, so they are shadowed from host writes
    logic [7:0] enh;
    logic [7:0] misc;
    logic [7:0] last_wd;
    logic auto_rts;
    wire logic wr_a = host.wr && host.chan;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enh <= 8'h00;
            misc <= 8'h00;
            last_wd <= 8'h00;
        end else begin
            if (chan_reset) begin
                enh <= 8'h00;
            end else if (wr_a && host.idx == reg_enh_enable) begin
                enh <= host.wdata;
            end
            if (chan_reset) begin
                misc <= 8'h00;
            end else if (wr_a && host.idx == reg_misc_ctrl) begin
                misc <= host.wdata;
            end
            if (host.wr) begin
                last_wd <= host.wdata;
            end
        end
    end
    assign auto_rts = enh[enh_opt_bit] && option_a[opt_auto_rts] && sdlc_mode_a && misc[misc_idle_bit]
        && !misc[misc_abort_bit];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_option_top_zero: assert property (!option_a[opt_must_zero])
        else $error("option top bit set");
    a_option_steer: assert property (wr_a && host.idx == reg_flag_pattern && enh[enh_opt_bit]
        |-> ##[1:2] option_a == {1'b0, last_wd[6:0]}) else $error("flag write not steered");
    a_frame_push: assert property (rx_end_of_frame[1] && fifo_enabled[1] && !frame_valid[1] && !chan_reset
        && sdlc_mode_a |-> ##[1:3] frame_valid[1]) else $error("frame entry not pushed");
    a_frame_hold: assert property (frame_valid[1] && !frame_ready[1] && fifo_enabled[1] && !chan_reset
        && !(host.wr && host.idx == reg_enh_enable) |=> frame_valid[1] && $stable(frame_a))
        else $error("frame entry lost while stalled");
    a_fifo_off_empty: assert property (!fifo_enabled[1] ##1 !fifo_enabled[1] |-> !frame_valid[1])
        else $error("frame valid while fifo off");
    a_crc_tail: assert property (rx_end_of_frame[1] && enh[enh_opt_bit] && option_a[opt_rx_crc]
        |-> ##[1:2] crc_tail_shift[1] [*2]) else $error("crc tail shift missing");
    a_crc_quiet: assert property (rx_end_of_frame[1] && !option_a[opt_rx_crc]
        |=> !crc_tail_shift[1] [*3]) else $error("crc tail shift without option");
    a_rts_follow: assert property (rts_host[1] && !chan_reset |=> rts_out[1])
        else $error("rts not following host");
    a_rts_hold: assert property (auto_rts && rts_out[1] && !closing_flag_done[1] && !chan_reset
        |=> rts_out[1]) else $error("auto rts dropped early");
    a_rts_release: assert property (!rts_host[1] && (!auto_rts || closing_flag_done[1])
        |=> !rts_out[1]) else $error("rts not released");
    a_rdata_stands: assert property (!host.rd && !chan_reset |=> $stable(rdata))
        else $error("read data changed without read");
endmodule // sdlc_enh_checker

bind sdlc_enhancement_register_map sdlc_enh_checker u_checker (.clk, .resetn, .chan_reset, .host, .rdata,
    .sdlc_mode_a, .rx_end_of_frame, .rts_host, .closing_flag_done, .frame_valid, .frame_ready, .frame_a,
    .rts_out, .crc_tail_shift, .fifo_enabled, .option_a);

// ---- tb/sdlc_station_model.sv ----
`timescale 1ns/100ps
module sdlc_station_model
    import sdlc_enh_pkg::*;
(
    // clock
    input wire logic clk,
    // receiver events, bit 1 is channel A
    output logic [1:0] rx_fifo_write,
    output logic [1:0] rx_flag_seen,
    output logic [1:0] rx_end_of_frame,
    output logic [status_w-1:0] rx_status_a,
    output logic [status_w-1:0] rx_status_b,
    // transmitter event
    output logic [1:0] closing_flag_done
);
    initial begin
        rx_fifo_write = 2'b00;
        rx_flag_seen = 2'b00;
        rx_end_of_frame = 2'b00;
        closing_flag_done = 2'b00;
        rx_status_a = 5'h0a;
        rx_status_b = 5'h15;
    end
    // gap idle cycles between bytes models a slow line
    task automatic bytes(input logic ch, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_fifo_write[ch] = 1'b1;
            repeat (gap) begin
                @(negedge clk);
                rx_fifo_write[ch] = 1'b0;
            end
        end
        @(negedge clk);
        rx_fifo_write[ch] = 1'b0;
    endtask
    // status holds one extra cycle, then flips so stale values cannot match
    task automatic close(input logic ch, input logic [status_w-1:0] st);
        @(negedge clk);
        {rx_status_a, rx_status_b} = ch ? {st, rx_status_b} : {rx_status_a, st};
        rx_flag_seen[ch] = 1'b1;
        rx_end_of_frame[ch] = 1'b1;
        @(negedge clk);
        rx_flag_seen[ch] = 1'b0;
        rx_end_of_frame[ch] = 1'b0;
        @(negedge clk);
        rx_status_a = ~rx_status_a;
        rx_status_b = ~rx_status_b;
    endtask
    task automatic done(input logic ch);
        @(negedge clk);
        closing_flag_done[ch] = 1'b1;
        @(negedge clk);
        closing_flag_done[ch] = 1'b0;
    endtask
endmodule // sdlc_station_model

// ---- tb/sdlc_enhancement_register_map_test.sv ----
`timescale 1ns/100ps
module sdlc_enhancement_register_map_test
    import sdlc_enh_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic chan_reset = 1'b0;
    host_req_t host = '0;
    logic [7:0] img = 8'h5a;
    logic sdlc_mode_a = 1'b1;
    logic sdlc_mode_b = 1'b1;
    logic [1:0] rts_host = 2'b00;
    logic [1:0] frame_ready = 2'b00;
    wire logic [7:0] main_status_a = img ^ 8'h01, main_status_b = img ^ 8'h02;
    wire logic [7:0] special_rx_a = img ^ 8'h03, special_rx_b = img ^ 8'h04;
    wire logic [7:0] vector_readback_a = img ^ 8'h05, vector_readback_b = img ^ 8'h06;
    wire logic [7:0] pending_irq = img ^ 8'h07, upper_status_a = img ^ 8'h08, upper_status_b = img ^ 8'h09;
    logic [7:0] rdata, option_a, option_b;
    logic [1:0] rx_fifo_write, rx_flag_seen, rx_end_of_frame, closing_flag_done, frame_valid;
    logic [1:0] rts_out, crc_tail_shift, fifo_enabled;
    logic [status_w-1:0] rx_status_a, rx_status_b;
    frame_entry_t frame_a, frame_b;
    logic [3:0] ix [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h9, 4'hb, 4'he};
    logic [7:0] ka [8] = '{8'h01, 8'h03, 8'h07, 8'h01, 8'h03, 8'h08, 8'h08, 8'h08};
    logic [7:0] kb [8] = '{8'h02, 8'h04, 8'h07, 8'h02, 8'h04, 8'h09, 8'h09, 8'h09};
    logic [3:0] xi [5] = '{4'h4, 4'h5, 4'h9, 4'hb, 4'he};
    logic [7:0] xv [5] = '{8'h41, 8'h51, 8'h31, 8'h08, 8'h7f};
    int err_count = 0, checked = 0, cycles = 0, crc_n = 0, base = 0;

    sdlc_enhancement_register_map DUT (.clk, .resetn, .chan_reset, .host, .rdata, .main_status_a,
        .main_status_b, .special_rx_a, .special_rx_b, .vector_readback_a, .vector_readback_b, .pending_irq,
        .upper_status_a, .upper_status_b, .sdlc_mode_a, .sdlc_mode_b, .rx_fifo_write, .rx_flag_seen,
        .rx_end_of_frame, .rx_status_a, .rx_status_b, .rts_host, .closing_flag_done, .frame_valid,
        .frame_ready, .frame_a, .frame_b, .rts_out, .crc_tail_shift, .fifo_enabled, .option_a, .option_b);
    sdlc_station_model stn (.clk, .rx_fifo_write, .rx_flag_seen, .rx_end_of_frame, .rx_status_a,
        .rx_status_b, .closing_flag_done);

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        crc_n += crc_tail_shift[1];
        if (cycles == 30000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic ch, input logic [3:0] idx, input logic [7:0] d);
        @(negedge clk);
        host = {1'b1, 1'b0, ch, idx, d};
        @(negedge clk);
        host = '0;
    endtask
    task automatic reg_read(input logic ch, input logic [3:0] idx, input logic [7:0] exp);
        @(negedge clk);
        host = {1'b0, 1'b1, ch, idx, 8'h00};
        @(negedge clk);
        host = '0;
        check(rdata, exp);
    endtask
    // waits a bounded time for the head entry, compares it, then takes it
    task automatic pop(input logic ch, input frame_entry_t exp);
        for (int n = 0; n < 20 && frame_valid[ch] !== 1'b1; n++) @(negedge clk);
        check({frame_valid[ch], ch ? frame_a : frame_b}, {1'b1, exp});
        frame_ready[ch] = 1'b1;
        @(negedge clk);
        frame_ready[ch] = 1'b0;
        @(negedge clk);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        check({option_a, rts_out, frame_valid, crc_tail_shift}, 14'h0000);
        reg_write(1, reg_enh_enable, 8'h04);
        reg_write(0, reg_enh_enable, 8'h04);
        check(fifo_enabled, 2'b11);
        for (int i = 0; i < 16; i++) reg_read(i[3], ix[i[2:0]], img ^ (i[3] ? ka[i[2:0]] : kb[i[2:0]]));
        reg_write(1, reg_flag_pattern, 8'h7e);
        check(option_a, 8'h00);
        stn.bytes(1, 3, 0);
        sdlc_mode_a = 1'b0;
        stn.bytes(1, 2, 0);
        sdlc_mode_a = 1'b1;
        stn.bytes(1, 4, 1);
        stn.close(1, 5'h15);
        reg_read(1, reg_frame_low, 8'h04);
        pop(1, {14'd4, 5'h15});
        stn.bytes(0, 2, 0);
        stn.close(0, 5'h0a);
        pop(0, {14'd2, 5'h0a});
        for (int n = 1; n < 4; n++) begin
            stn.bytes(1, n, 0);
            stn.close(1, n[4:0]);
        end
        reg_read(1, reg_frame_high, 8'hc0);
        for (int n = 1; n < 3; n++) pop(1, {n[13:0], n[4:0]});
        check(frame_valid, 2'b00);
        stn.bytes(1, 5, 0);
        chan_reset = 1'b1;
        @(negedge clk);
        chan_reset = 1'b0;
        reg_write(1, reg_enh_enable, 8'h04);
        stn.bytes(1, 16383, 0);
        stn.close(1, 5'h1f);
        reg_read(1, reg_frame_low, 8'hff);
        pop(1, {14'h3fff, 5'h1f});
        img = 8'hc3;
        reg_write(1, reg_enh_enable, 8'h05);
        reg_write(1, reg_flag_pattern, 8'hff);
        reg_write(0, reg_enh_enable, 8'h01);
        reg_write(0, reg_flag_pattern, 8'h2a);
        check({option_a, option_b}, 16'h7f2a);
        reg_write(1, reg_rx_param, 8'h31);
        reg_write(1, reg_txrx_mode, 8'h41);
        reg_write(1, reg_tx_param, 8'h51);
        reg_write(1, reg_misc_ctrl, 8'h08);
        stn.bytes(1, 6, 2);
        base = crc_n;
        stn.close(1, 5'h03);
        repeat (3) @(negedge clk);
        check(crc_n - base, 20'h2);
        reg_read(1, reg_frame_low, 8'h06);
        for (int i = 0; i < 5; i++) reg_read(1, xi[i], xv[i]);
        pop(1, {14'd6, 5'h03});
        reg_write(1, reg_enh_enable, 8'h01);
        reg_read(1, reg_frame_low, img ^ 8'h05);
        reg_read(1, reg_frame_high, img ^ 8'h07);
        reg_read(1, reg_txrx_mode, 8'h41);
        rts_host = 2'b10;
        repeat (2) @(negedge clk);
        check(rts_out, 2'b10);
        rts_host = 2'b00;
        repeat (4) @(negedge clk);
        check(rts_out, 2'b10);
        stn.done(1);
        @(negedge clk);
        check(rts_out, 2'b00);
        reg_write(1, reg_flag_pattern, 8'h40);
        reg_read(1, reg_ext_e, 8'h40);
        rts_host = 2'b10;
        repeat (2) @(negedge clk);
        rts_host = 2'b00;
        repeat (2) @(negedge clk);
        check(rts_out, 2'b00);
        base = crc_n;
        stn.close(1, 5'h01);
        repeat (3) @(negedge clk);
        check(crc_n - base, 20'h0);
        // extended read bit left set, enable bit 0 cleared: plain images return
        reg_write(1, reg_enh_enable, 8'h00);
        reg_read(1, reg_txrx_mode, img ^ 8'h01);
        finish_test();
    end
endmodule // sdlc_enhancement_register_map_test
